// [gsfl_nav_model.sv]
// Purpose: navigation receiver model driving the nav serial line
// Assumes: line idles at mark level between characters
// Notes: bit time given per character so one model serves every rate
`timescale 1ns/1ps
`default_nettype none
module gsfl_nav_model (
  input wire logic clk,
  output logic nav_line
);
  initial nav_line = 1'b1;
  // Start low, data LSB first, stop high
  task automatic send(input logic [7:0] b, input int cyc);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      nav_line = fr[i];
      repeat (cyc) @(negedge clk);
    end
  endtask
endmodule // gsfl_nav_model
`default_nettype wire

// [gsfl_pkg.sv]
// Purpose: constants and types for the navigation serial link and fuel data port
// Assumes: single 125 MHz clock, synchronous active-high reset
// Notes: bit-period counts are defaults for the top-level parameters
// Functional notes
// - The navigation input takes 8N1 characters at 1200, 4800 or 9600 baud, set by the format.
// - The incoming format is found automatically, with no selection and regardless of the code.
// - Aviation format needs first id byte A,B,C,D,E,I or L and accepts CR LF or CR alone.
// - The fuel data output sends 8N1 characters at a fixed 9600 baud.
// - Detected marine or binary navigation input forces fuel output off.
// - With no incoming characters, required, reserve and economy are hidden with no message.
// - With characters but no lock, the no-communication message shows and all three hide.
// - With insufficient signal reported, the no-signal message shows and all three hide.
// - With valid data but no waypoint, no-waypoint shows and only required and reserve hide.
package gsfl_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned BAUD_AVN = 9600;
  localparam int unsigned BAUD_NMEA = 4800;
  localparam int unsigned BAUD_BIN = 1200;
  localparam int unsigned BAUD_TX = 9600;
  localparam int unsigned BIT_CYC_AVN = CLK_HZ / BAUD_AVN;
  localparam int unsigned BIT_CYC_NMEA = CLK_HZ / BAUD_NMEA;
  localparam int unsigned BIT_CYC_BIN = CLK_HZ / BAUD_BIN;
  localparam int unsigned BIT_CYC_TX = CLK_HZ / BAUD_TX;
  localparam int unsigned SILENCE_MS = 1000;
  localparam int unsigned SILENCE_CYC = (CLK_HZ / 1000) * SILENCE_MS;
  localparam int unsigned CNT_W = 27;
  localparam int unsigned HUNT_CHARS = 16;
  localparam int unsigned LOCK_CHARS_BIN = 8;

  localparam logic [7:0] CHR_CR = 8'h0d;
  localparam logic [7:0] CHR_LF = 8'h0a;
  localparam logic [7:0] CHR_DOLLAR = 8'h24;
  localparam logic [7:0] CHR_ID_A = 8'h41;
  localparam logic [7:0] CHR_ID_B = 8'h42;
  localparam logic [7:0] CHR_ID_C = 8'h43;
  localparam logic [7:0] CHR_ID_D = 8'h44;
  localparam logic [7:0] CHR_ID_E = 8'h45;
  localparam logic [7:0] CHR_ID_I = 8'h49;
  localparam logic [7:0] CHR_ID_L = 8'h4c;

  localparam logic [3:0] FOC_OFF = 4'h0;
  localparam logic [3:0] FOC_FMT1 = 4'h1;
  localparam logic [3:0] FOC_FMT2_WPT = 4'h2;
  localparam logic [3:0] FOC_FMT3 = 4'h3;
  localparam logic [3:0] FOC_FMT4 = 4'h4;
  localparam logic [3:0] FOC_UNUSED = 4'h5;
  localparam logic [3:0] FOC_FMT5_WPT = 4'h6;
  localparam logic [3:0] FOC_FMT5_DST = 4'h7;
  localparam logic [3:0] FOC_FMT2_DST = 4'h8;

  typedef enum logic [1:0] {GSFL_FMT_AVN, GSFL_FMT_NMEA, GSFL_FMT_BIN} gsfl_fmt_e;
  typedef enum logic [1:0] {GSFL_MSG_NONE, GSFL_MSG_NO_COM, GSFL_MSG_NO_SIG,
                            GSFL_MSG_NO_WAYPOINT_MSG} gsfl_msg_e;
  typedef enum logic [2:0] {GSFL_TXF_OFF, GSFL_TXF_1, GSFL_TXF_2, GSFL_TXF_3, GSFL_TXF_4,
                            GSFL_TXF_5} gsfl_txf_e;
endpackage

// [gsfl_properties.sv]
// Purpose: port-level checks for the nav link and the fuel data port
// Assumes: sees gsfl_top ports only; bit period handed on by bind
// Notes: start-bit check needs a bit period of at least eight cycles
`timescale 1ns/1ps
`default_nettype none
module gsfl_properties #(
  parameter int unsigned BIT_CYC_TX = 16
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [3:0] FUEL_OUTPUT_FORMAT_CODE,
  input wire logic SIG_VALID,
  input wire logic WAYPOINT_SET,
  input wire logic TX_VALID,
  input wire logic TX_READY,
  input wire logic FUEL_TXD,
  input wire logic RX_VALID,
  input wire logic FORMAT_LOCKED,
  input wire gsfl_pkg::gsfl_fmt_e DETECTED_FORMAT,
  input wire gsfl_pkg::gsfl_txf_e TX_FORMAT,
  input wire gsfl_pkg::gsfl_msg_e MESSAGE,
  input wire logic SHOW_FUEL_REQUIRED,
  input wire logic SHOW_FUEL_RESERVE_PARAM,
  input wire logic SHOW_FUEL_ECONOMY_PARAM
);
  import gsfl_pkg::*;
  logic [31:0] busy_cnt;
  // Counts a busy run so a stuck transmitter is caught
  always_ff @(posedge CLK) begin
    if (RESET || TX_READY)
      busy_cnt <= 32'h0;
    else
      busy_cnt <= busy_cnt + 32'h1;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  // Start bit leaves one cycle after READY drops
  tx_start_a: assert property (TX_VALID && TX_READY && TX_FORMAT != GSFL_TXF_OFF
    |=> !TX_READY ##1 !FUEL_TXD) else $error("fuel start bit missing");
  start_len_a: assert property ($fell(FUEL_TXD) |-> !FUEL_TXD [*8])
    else $error("fuel start bit too short");
  busy_len_a: assert property (busy_cnt <= 10 * BIT_CYC_TX + 4)
    else $error("fuel character too long");
  stop_idle_a: assert property ($rose(TX_READY) |-> FUEL_TXD)
    else $error("fuel line low when idle");
  code_off_a: assert property (FUEL_OUTPUT_FORMAT_CODE inside {4'h0, 4'h5}
    |=> TX_FORMAT == GSFL_TXF_OFF) else $error("code should disable output");
  lock_mute_a: assert property (FORMAT_LOCKED && DETECTED_FORMAT != GSFL_FMT_AVN
    |=> TX_FORMAT == GSFL_TXF_OFF) else $error("fuel output not muted");
  rx_pulse_a: assert property (RX_VALID |-> FORMAT_LOCKED ##1 !RX_VALID)
    else $error("receive pulse wrong");
  hide_unlocked_a: assert property (!FORMAT_LOCKED |=> !SHOW_FUEL_REQUIRED
    && !SHOW_FUEL_RESERVE_PARAM && !SHOW_FUEL_ECONOMY_PARAM) else $error("shown unlocked");
  no_sig_a: assert property (FORMAT_LOCKED && !SIG_VALID |=> MESSAGE == GSFL_MSG_NO_SIG
    && !SHOW_FUEL_ECONOMY_PARAM && !SHOW_FUEL_REQUIRED) else $error("no-signal display");
  no_waypoint_msg_a: assert property (FORMAT_LOCKED && SIG_VALID && !WAYPOINT_SET
    |=> MESSAGE == GSFL_MSG_NO_WAYPOINT_MSG && SHOW_FUEL_ECONOMY_PARAM && !SHOW_FUEL_RESERVE_PARAM)
    else $error("no-waypoint display");
  cover property (FORMAT_LOCKED && DETECTED_FORMAT == GSFL_FMT_BIN);
  cover property (RX_VALID);
  cover property ($fell(FUEL_TXD));
endmodule // gsfl_properties
`default_nettype wire

// [gsfl_top.sv]
// Purpose: navigation receive with automatic format detection, fuel data transmit
// Assumes: NAV_RXD is an asynchronous pin; SIG_VALID and WAYPOINT_SET come from
//   the sentence decoder on CLK
// Notes: fuel bytes are accepted and dropped while output is disabled
`timescale 1ns/1ps
`default_nettype none
module gsfl_top #(
  parameter int unsigned BIT_CYC_AVN = gsfl_pkg::BIT_CYC_AVN,
  parameter int unsigned BIT_CYC_NMEA = gsfl_pkg::BIT_CYC_NMEA,
  parameter int unsigned BIT_CYC_BIN = gsfl_pkg::BIT_CYC_BIN,
  parameter int unsigned BIT_CYC_TX = gsfl_pkg::BIT_CYC_TX,
  parameter int unsigned SILENCE_CYC = gsfl_pkg::SILENCE_CYC
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic NAV_RXD,
  input wire logic [3:0] FUEL_OUTPUT_FORMAT_CODE,
  input wire logic SIG_VALID,
  input wire logic WAYPOINT_SET,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_VALID,
  output logic TX_READY,
  output logic FUEL_TXD,
  output logic [7:0] RX_DATA,
  output logic RX_VALID,
  output logic FORMAT_LOCKED,
  output gsfl_pkg::gsfl_fmt_e DETECTED_FORMAT,
  output gsfl_pkg::gsfl_txf_e TX_FORMAT,
  output logic TX_TO_DEST,
  output gsfl_pkg::gsfl_msg_e MESSAGE,
  output logic SHOW_FUEL_REQUIRED,
  output logic SHOW_FUEL_RESERVE_PARAM,
  output logic SHOW_FUEL_ECONOMY_PARAM
);
  import gsfl_pkg::*;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA_S, RX_STOP} gsfl_rx_e;

  logic rx_meta, rx_s, rx_prev;
  gsfl_rx_e rx_state;
  logic [CNT_W-1:0] rx_cnt, bit_cyc;
  logic [2:0] rx_bit;
  logic [7:0] rx_shift;
  logic char_done, frame_ok;
  logic [7:0] char_byte;
  gsfl_fmt_e cand;
  logic locked, active, cr_seen;
  logic [4:0] hunt_cnt;
  logic [CNT_W-1:0] quiet_cnt;
  logic id_ok;
  logic tx_en;
  logic [9:0] tx_shift;
  logic [3:0] tx_left;
  logic [CNT_W-1:0] tx_cnt;

  // Two flops before any logic looks at the pin
  always_ff @(posedge CLK) begin
    if (RESET) begin
      rx_meta <= 1'b1;
      rx_s <= 1'b1;
      rx_prev <= 1'b1;
    end else begin
      rx_meta <= NAV_RXD;
      rx_s <= rx_meta;
      rx_prev <= rx_s;
    end
  end

  // Bit period follows the candidate under test
  always_comb begin
    unique case (cand)
      GSFL_FMT_AVN: bit_cyc = CNT_W'(BIT_CYC_AVN);
      GSFL_FMT_NMEA: bit_cyc = CNT_W'(BIT_CYC_NMEA);
      default: bit_cyc = CNT_W'(BIT_CYC_BIN);
    endcase
  end

  // 8N1 receiver, sampled mid-bit
  always_ff @(posedge CLK) begin
    if (RESET) begin
      rx_state <= RX_IDLE;
      rx_cnt <= '0;
      rx_bit <= '0;
      rx_shift <= '0;
      char_done <= 1'b0;
      frame_ok <= 1'b0;
      char_byte <= '0;
    end else begin
      char_done <= 1'b0;
      if (rx_state != RX_IDLE && rx_cnt != '0) begin
        rx_cnt <= rx_cnt - 1'b1;
      end else begin
        unique case (rx_state)
          RX_IDLE: begin
            if (rx_prev && !rx_s) begin
              rx_state <= RX_START;
              rx_cnt <= bit_cyc >> 1;
            end
          end
          RX_START: begin
            // Glitch shorter than half a bit is dropped
            rx_state <= rx_s ? RX_IDLE : RX_DATA_S;
            rx_cnt <= bit_cyc - 1'b1;
            rx_bit <= '0;
          end
          RX_DATA_S: begin
            rx_shift <= {rx_s, rx_shift[7:1]};
            rx_cnt <= bit_cyc - 1'b1;
            rx_bit <= rx_bit + 1'b1;
            if (rx_bit == 3'h7) begin
              rx_state <= RX_STOP;
            end
          end
          RX_STOP: begin
            rx_state <= RX_IDLE;
            char_done <= 1'b1;
            frame_ok <= rx_s;
            char_byte <= rx_shift;
          end
        endcase
      end
    end
  end

  assign id_ok = (char_byte == CHR_ID_A) || (char_byte == CHR_ID_B) ||
                 (char_byte == CHR_ID_C) || (char_byte == CHR_ID_D) ||
                 (char_byte == CHR_ID_E) || (char_byte == CHR_ID_I) ||
                 (char_byte == CHR_ID_L);

  // Line activity: any start edge counts, silence clears it and the lock
  always_ff @(posedge CLK) begin
    if (RESET) begin
      quiet_cnt <= '0;
      active <= 1'b0;
    end else if (rx_prev && !rx_s) begin
      quiet_cnt <= '0;
      active <= 1'b1;
    end else if (quiet_cnt >= CNT_W'(SILENCE_CYC - 1)) begin
      active <= 1'b0;
    end else begin
      quiet_cnt <= quiet_cnt + 1'b1;
    end
  end

  // Format hunt: no user input involved, only the line itself
  always_ff @(posedge CLK) begin
    if (RESET) begin
      cand <= GSFL_FMT_AVN;
      locked <= 1'b0;
      hunt_cnt <= '0;
      cr_seen <= 1'b0;
    end else if (!active) begin
      locked <= 1'b0;
      hunt_cnt <= '0;
      cr_seen <= 1'b0;
    end else if (char_done && !locked) begin
      if (!frame_ok || hunt_cnt == 5'(HUNT_CHARS - 1)) begin
        // Wrong rate or no structure seen: try the next rate
        cand <= (cand == GSFL_FMT_BIN) ? GSFL_FMT_AVN : gsfl_fmt_e'(cand + 2'h1);
        hunt_cnt <= '0;
        cr_seen <= 1'b0;
      end else begin
        hunt_cnt <= hunt_cnt + 1'b1;
        unique case (cand)
          GSFL_FMT_AVN: begin
            // LF after CR keeps the terminator open, so CR alone also works
            cr_seen <= (char_byte == CHR_CR) || (cr_seen && char_byte == CHR_LF);
            if (cr_seen && id_ok) begin
              locked <= 1'b1;
            end
          end
          GSFL_FMT_NMEA: begin
            if (char_byte == CHR_DOLLAR) begin
              locked <= 1'b1;
            end
          end
          default: begin
            // Binary has no text marker; rely on a clean run of frames
            if (hunt_cnt == 5'(LOCK_CHARS_BIN - 1)) begin
              locked <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      RX_DATA <= '0;
      RX_VALID <= 1'b0;
    end else begin
      RX_VALID <= char_done && frame_ok && locked;
      if (char_done) begin
        RX_DATA <= char_byte;
      end
    end
  end

  // Drops in the cycle the line goes quiet, not one cycle after
  assign FORMAT_LOCKED = locked && active;
  assign DETECTED_FORMAT = cand;

  // Code to transmit format
  always_ff @(posedge CLK) begin
    if (RESET) begin
      TX_FORMAT <= GSFL_TXF_OFF;
      TX_TO_DEST <= 1'b0;
    end else begin
      TX_TO_DEST <= (FUEL_OUTPUT_FORMAT_CODE == FOC_FMT2_DST) ||
                    (FUEL_OUTPUT_FORMAT_CODE == FOC_FMT5_DST);
      if (locked && (cand == GSFL_FMT_NMEA || cand == GSFL_FMT_BIN)) begin
        TX_FORMAT <= GSFL_TXF_OFF;
      end else begin
        unique case (FUEL_OUTPUT_FORMAT_CODE)
          FOC_FMT1: TX_FORMAT <= GSFL_TXF_1;
          FOC_FMT2_WPT, FOC_FMT2_DST: TX_FORMAT <= GSFL_TXF_2;
          FOC_FMT3: TX_FORMAT <= GSFL_TXF_3;
          FOC_FMT4: TX_FORMAT <= GSFL_TXF_4;
          FOC_FMT5_WPT, FOC_FMT5_DST: TX_FORMAT <= GSFL_TXF_5;
          default: TX_FORMAT <= GSFL_TXF_OFF;
        endcase
      end
    end
  end

  assign tx_en = (TX_FORMAT != GSFL_TXF_OFF);
  assign TX_READY = (tx_left == '0);

  // 8N1 transmitter at the fixed rate; bytes offered while off are dropped
  always_ff @(posedge CLK) begin
    if (RESET) begin
      tx_shift <= '1;
      tx_left <= '0;
      tx_cnt <= '0;
      FUEL_TXD <= 1'b1;
    end else if (tx_left == '0) begin
      FUEL_TXD <= 1'b1;
      if (TX_VALID && tx_en) begin
        tx_shift <= {1'b1, TX_DATA, 1'b0};
        // Ten bits plus one idle slot, so the stop bit runs a full period
        tx_left <= 4'hb;
        tx_cnt <= '0;
      end
    end else if (tx_cnt == '0) begin
      FUEL_TXD <= tx_shift[0];
      tx_shift <= {1'b1, tx_shift[9:1]};
      tx_left <= tx_left - 1'b1;
      tx_cnt <= CNT_W'(BIT_CYC_TX - 1);
    end else begin
      tx_cnt <= tx_cnt - 1'b1;
    end
  end

  // Display scan and diagnostic message
  always_ff @(posedge CLK) begin
    if (RESET) begin
      MESSAGE <= GSFL_MSG_NONE;
      SHOW_FUEL_REQUIRED <= 1'b0;
      SHOW_FUEL_RESERVE_PARAM <= 1'b0;
      SHOW_FUEL_ECONOMY_PARAM <= 1'b0;
    end else if (!active) begin
      MESSAGE <= GSFL_MSG_NONE;
      SHOW_FUEL_REQUIRED <= 1'b0;
      SHOW_FUEL_RESERVE_PARAM <= 1'b0;
      SHOW_FUEL_ECONOMY_PARAM <= 1'b0;
    end else if (!locked) begin
      MESSAGE <= GSFL_MSG_NO_COM;
      SHOW_FUEL_REQUIRED <= 1'b0;
      SHOW_FUEL_RESERVE_PARAM <= 1'b0;
      SHOW_FUEL_ECONOMY_PARAM <= 1'b0;
    end else if (!SIG_VALID) begin
      MESSAGE <= GSFL_MSG_NO_SIG;
      SHOW_FUEL_REQUIRED <= 1'b0;
      SHOW_FUEL_RESERVE_PARAM <= 1'b0;
      SHOW_FUEL_ECONOMY_PARAM <= 1'b0;
    end else if (!WAYPOINT_SET) begin
      MESSAGE <= GSFL_MSG_NO_WAYPOINT_MSG;
      SHOW_FUEL_REQUIRED <= 1'b0;
      SHOW_FUEL_RESERVE_PARAM <= 1'b0;
      SHOW_FUEL_ECONOMY_PARAM <= 1'b1;
    end else begin
      MESSAGE <= GSFL_MSG_NONE;
      SHOW_FUEL_REQUIRED <= 1'b1;
      SHOW_FUEL_RESERVE_PARAM <= 1'b1;
      SHOW_FUEL_ECONOMY_PARAM <= 1'b1;
    end
  end
endmodule // gsfl_top
`default_nettype wire

// [gsfl_top_bench.sv]
// Purpose: self-checking bench for gsfl_top against a queue model
// Assumes: shortened bit periods and silence time set below
// Notes: display and tx format outputs compared two cycles after each code, sig or wpt change
`timescale 1ns/1ps
`default_nettype none
module gsfl_top_bench;
  import gsfl_pkg::*;
  localparam int BA = 16, BN = 32, BB = 64, BT = 16, SIL = 2000;
  logic clk, reset, nav, sig, wpt, tx_valid, tx_ready, txd, rx_valid, locked, to_dest;
  logic s_req, s_res, s_eco;
  logic [3:0] code;
  logic [7:0] tx_data, rx_data, rb;
  gsfl_fmt_e det;
  gsfl_txf_e txf;
  gsfl_msg_e msg;
  int bad_count = 0;
  int checked = 0;
  logic [31:0] seed = 32'h261305a6;
  logic [7:0] rxq[$];
  logic [7:0] expq[$];
  logic [7:0] ids[7] = '{CHR_ID_A, CHR_ID_B, CHR_ID_C, CHR_ID_D, CHR_ID_E, CHR_ID_I, CHR_ID_L};
  string sen = "$GPRMB";
  gsfl_top #(.BIT_CYC_AVN(BA), .BIT_CYC_NMEA(BN), .BIT_CYC_BIN(BB), .BIT_CYC_TX(BT),
    .SILENCE_CYC(SIL)) gsfl_top_inst (.CLK(clk), .RESET(reset), .NAV_RXD(nav),
    .FUEL_OUTPUT_FORMAT_CODE(code), .SIG_VALID(sig), .WAYPOINT_SET(wpt), .TX_DATA(tx_data),
    .TX_VALID(tx_valid), .TX_READY(tx_ready), .FUEL_TXD(txd), .RX_DATA(rx_data),
    .RX_VALID(rx_valid), .FORMAT_LOCKED(locked), .DETECTED_FORMAT(det), .TX_FORMAT(txf),
    .TX_TO_DEST(to_dest), .MESSAGE(msg), .SHOW_FUEL_REQUIRED(s_req),
    .SHOW_FUEL_RESERVE_PARAM(s_res), .SHOW_FUEL_ECONOMY_PARAM(s_eco));
  gsfl_nav_model gsfl_nav_model_inst (.clk(clk), .nav_line(nav));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) if (rx_valid === 1'b1) rxq.push_back(rx_data);
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // Expected {to_dest, family} per code
  function automatic logic [3:0] exp_fmt(input logic [3:0] c);
    case (c)
      4'h1, 4'h2, 4'h3, 4'h4: return c;
      4'h6: return 4'h5;
      4'h7: return 4'hd;
      4'h8: return 4'ha;
      default: return 4'h0;
    endcase
  endfunction
  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    if (bad_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic disp(input logic [4:0] exp);
    tick(2);
    chk("display", exp, {msg, s_req, s_res, s_eco});
  endtask
  task automatic fuel(input logic on);
    logic [9:0] got;
    logic [7:0] b;
    int n;
    logic rdy;
    b = rnd();
    n = 0;
    while (tx_ready !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    if (n == 400) begin
      bad_count++;
      tally_and_finish();
    end
    tx_data = b;
    tx_valid = 1'b1;
    tick(1);
    tx_valid = 1'b0;
    tick(7);
    for (int i = 0; i < 10; i++) begin
      got[i] = txd;
      if (i == 9) rdy = tx_ready;
      tick(BT);
    end
    chk("fuel frame", on ? {1'b1, b, 1'b0} : 10'h3ff, got);
    // Stop bit must still count as busy
    chk("stop busy", on ? 10'h000 : 10'h001, {9'h000, rdy});
  endtask
  initial begin
    reset = 1'b1;
    code = 4'h0;
    sig = 1'b0;
    wpt = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    repeat (20) @(posedge clk);
    tick(1);
    reset = 1'b0;
    disp(5'h00);
    for (int c = 0; c < 16; c++) begin
      code = c[3:0];
      tick(2);
      chk("tx format", exp_fmt(c[3:0]), {to_dest, txf});
    end
    code = 4'h1;
    // Format register follows the code one cycle late
    tick(2);
    fuel(1'b1);
    gsfl_nav_model_inst.send(8'h31, BA);
    disp(5'h08);
    for (int k = 0; k < 7; k++) begin
      gsfl_nav_model_inst.send(CHR_CR, BA);
      if (k[0]) gsfl_nav_model_inst.send(CHR_LF, BA);
      gsfl_nav_model_inst.send(ids[k], BA);
      tick(4);
      chk("aviation lock", {1'b1, GSFL_FMT_AVN}, {locked, det});
      tick(SIL + 40);
      chk("silence unlock", 3'h0, {locked, msg});
    end
    gsfl_nav_model_inst.send(CHR_CR, BA);
    gsfl_nav_model_inst.send(CHR_ID_A, BA);
    tick(4);
    rxq.delete();
    for (int k = 0; k < 3; k++) begin
      rb = rnd();
      expq.push_back(rb);
      gsfl_nav_model_inst.send(rb, BA);
    end
    tick(4);
    chk("rx count", 10'(expq.size()), 10'(rxq.size()));
    foreach (expq[i]) begin
      // A missing byte is forced to mismatch
      rb = (rxq.size() > i) ? rxq[i] : ~expq[i];
      chk("rx byte", expq[i], rb);
    end
    disp(5'h10);
    sig = 1'b1;
    disp(5'h19);
    wpt = 1'b1;
    disp(5'h07);
    fuel(1'b1);
    tick(SIL + 40);
    gsfl_nav_model_inst.send(8'h00, BN);
    for (int i = 0; i < 6; i++) gsfl_nav_model_inst.send(sen[i], BN);
    tick(4);
    chk("marine lock", {1'b1, GSFL_FMT_NMEA}, {locked, det});
    chk("marine mute", GSFL_TXF_OFF, txf);
    fuel(1'b0);
    tick(SIL + 40);
    gsfl_nav_model_inst.send(8'h00, BB);
    for (int i = 0; i < 8; i++) gsfl_nav_model_inst.send(rnd(), BB);
    tick(4);
    chk("binary lock", {1'b1, GSFL_FMT_BIN}, {locked, det});
    chk("binary mute", GSFL_TXF_OFF, txf);
    tally_and_finish();
  end
endmodule // gsfl_top_bench
bind gsfl_top gsfl_properties #(.BIT_CYC_TX(BIT_CYC_TX)) gsfl_properties_inst (.CLK(CLK),
  .RESET(RESET), .FUEL_OUTPUT_FORMAT_CODE(FUEL_OUTPUT_FORMAT_CODE), .SIG_VALID(SIG_VALID),
  .WAYPOINT_SET(WAYPOINT_SET), .TX_VALID(TX_VALID), .TX_READY(TX_READY), .FUEL_TXD(FUEL_TXD),
  .RX_VALID(RX_VALID), .FORMAT_LOCKED(FORMAT_LOCKED), .DETECTED_FORMAT(DETECTED_FORMAT),
  .TX_FORMAT(TX_FORMAT), .MESSAGE(MESSAGE), .SHOW_FUEL_REQUIRED(SHOW_FUEL_REQUIRED),
  .SHOW_FUEL_RESERVE_PARAM(SHOW_FUEL_RESERVE_PARAM),
  .SHOW_FUEL_ECONOMY_PARAM(SHOW_FUEL_ECONOMY_PARAM));
`default_nettype wire
